/* File: rtl/fwp_write_port.sv */
// Write port front end with strap capture at master reset
`timescale 1ns/1ps

module fwp_write_port
(
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // Master reset pin, active low
   input  wire logic                        master_reset_n,
   // Straps
   input  wire logic                        async_write_select_n,
   input  wire logic [fwp_pkg::OSEL_W-1:0]  flag_offset_select,
   input  wire logic                        fall_through_mode_select,
   input  wire logic                        depth_expansion_select,
   input  wire logic [fwp_pkg::BMS_W-1:0]   bus_width_select,
   // Producer write port
   input  wire logic                        write_clock,
   input  wire logic                        write_enable_n,
   input  wire logic                        write_chip_select_n,
   input  wire logic [fwp_pkg::DATA_W-1:0]  write_data,
   // Storage side stream
   output logic                             store_valid,
   input  wire logic                        store_ready,
   output logic [fwp_pkg::DATA_W-1:0]       store_data,
   input  wire logic                        store_full,
   // Configuration and status
   output logic [fwp_pkg::OFFS_W-1:0]       almost_empty_offset,
   output logic [fwp_pkg::OFFS_W-1:0]       almost_full_offset,
   output logic                             fall_through_mode,
   output logic [fwp_pkg::PWID_W-1:0]       write_port_width,
   output logic [fwp_pkg::PWID_W-1:0]       read_port_width,
   output logic                             full_flag_n,
   output logic                             write_pointer_clear,
   output logic                             drop_count_pulse
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed
   {
      logic                       sync_sel;
      logic [fwp_pkg::OSEL_W-1:0] offs_sel;
      logic                       fall_sel;
      logic                       depth_sel;
      logic [fwp_pkg::BMS_W-1:0]  width_sel;
   } fwp_strap_s;

   typedef struct packed
   {
      logic [1:0]                 mreset_sync;
      logic [1:0]                 clk_sync;
      logic                       clk_last;
      logic [1:0]                 en_sync;
      logic [1:0]                 cs_sync;
      fwp_strap_s                 strap_s1;
      fwp_strap_s                 strap_s2;
      logic [fwp_pkg::DATA_W-1:0] d_s1;
      logic [fwp_pkg::DATA_W-1:0] d_s2;
      fwp_pkg::fwp_state_e        state;
      logic                       sync_mode;
      logic                       fall_thru;
      logic                       depth_exp;
      logic [fwp_pkg::OFFS_W-1:0] offs;
      logic [fwp_pkg::PWID_W-1:0] wwid;
      logic [fwp_pkg::PWID_W-1:0] rwid;
      logic                       cap_valid;
      logic [fwp_pkg::DATA_W-1:0] cap_data;
      logic                       full_out_n;
      logic                       drop;
   } fwp_port_s;

   fwp_port_s  st_ff;
   fwp_port_s  nxt_st;
   fwp_strap_s strap_in;
   logic       buf_in_ready;
   logic       in_reset;
   logic       rise;
   logic       take;

   assign in_reset = !st_ff.mreset_sync[1];
   assign rise     = st_ff.clk_sync[1] && !st_ff.clk_last;
   // Sync mode needs enable; async mode ignores enable and takes every selected edge
   assign take = rise && !st_ff.cs_sync[1]
              && (!st_ff.sync_mode || !st_ff.en_sync[1]);

   // ----------------------------------------
   // Strap inputs
   // ----------------------------------------
   // Straps are pins: two flops before capture
   assign strap_in = '{sync_sel  : async_write_select_n,
                       offs_sel  : flag_offset_select,
                       fall_sel  : fall_through_mode_select,
                       depth_sel : depth_expansion_select,
                       width_sel : bus_width_select};

   // ----------------------------------------
   // Offset and width decode
   // ----------------------------------------
   function automatic logic [fwp_pkg::OFFS_W-1:0] dec_offs(input logic [1:0] s);
      unique case (s)
         2'h0: dec_offs = fwp_pkg::OFFS_SEL0;
         2'h1: dec_offs = fwp_pkg::OFFS_SEL1;
         2'h2: dec_offs = fwp_pkg::OFFS_SEL2;
         2'h3: dec_offs = fwp_pkg::OFFS_SEL3;
      endcase
   endfunction

   function automatic logic [fwp_pkg::PWID_W-1:0] dec_wid(input logic [1:0] s);
      unique case (s)
         2'h0:    dec_wid = fwp_pkg::PWID_X36;
         2'h1:    dec_wid = fwp_pkg::PWID_X18;
         default: dec_wid = fwp_pkg::PWID_X9;
      endcase
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      nxt_st             = st_ff;
      nxt_st.mreset_sync = {st_ff.mreset_sync[0], master_reset_n};
      nxt_st.clk_sync    = {st_ff.clk_sync[0], write_clock};
      nxt_st.clk_last    = st_ff.clk_sync[1];
      nxt_st.en_sync     = {st_ff.en_sync[0], write_enable_n};
      nxt_st.cs_sync     = {st_ff.cs_sync[0], write_chip_select_n};
      nxt_st.strap_s1    = strap_in;
      nxt_st.strap_s2    = st_ff.strap_s1;
      nxt_st.d_s1        = write_data;
      nxt_st.d_s2        = st_ff.d_s1;
      nxt_st.drop        = 1'b0;
      unique case (st_ff.state)
         fwp_pkg::FWP_ST_RESET:
         begin
            // Capture straps throughout master reset
            nxt_st.sync_mode = st_ff.strap_s2.sync_sel;
            nxt_st.fall_thru = st_ff.strap_s2.fall_sel;
            nxt_st.depth_exp = st_ff.strap_s2.depth_sel;
            nxt_st.offs      = dec_offs(st_ff.strap_s2.offs_sel);
            nxt_st.wwid      = dec_wid(st_ff.strap_s2.width_sel[3:2]);
            nxt_st.rwid      = dec_wid(st_ff.strap_s2.width_sel[1:0]);
            nxt_st.cap_valid = 1'b0;
            nxt_st.cap_data  = '0;
            if (!in_reset)
               nxt_st.state = fwp_pkg::FWP_ST_RUN;
         end
         fwp_pkg::FWP_ST_RUN:
         begin
            if (st_ff.cap_valid && buf_in_ready)
               nxt_st.cap_valid = 1'b0;
            if (take)
            begin
               if (st_ff.cap_valid && !buf_in_ready)
                  nxt_st.drop = 1'b1;
               else
               begin
                  nxt_st.cap_valid = 1'b1;
                  nxt_st.cap_data  = st_ff.d_s2;
               end
            end
            if (in_reset)
               nxt_st.state = fwp_pkg::FWP_ST_RESET;
         end
      endcase
      // Full in standard mode, input ready in fall-through mode or with depth expansion
      if (st_ff.fall_thru)
         nxt_st.full_out_n = store_full || !buf_in_ready;
      else
         nxt_st.full_out_n = st_ff.depth_exp ? (store_full || !buf_in_ready)
                                             : !(store_full || !buf_in_ready);
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff            <= '0;
         st_ff.full_out_n <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   // ----------------------------------------
   // Data buffer
   // ----------------------------------------
   fwp_skid_buf u_buf
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (st_ff.cap_valid),
      .in_ready  (buf_in_ready),
      .in_data   (st_ff.cap_data),
      .out_valid (store_valid),
      .out_ready (store_ready),
      .out_data  (store_data)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign almost_empty_offset = st_ff.offs;
   assign almost_full_offset  = st_ff.offs;
   assign fall_through_mode   = st_ff.fall_thru;
   assign write_port_width    = st_ff.wwid;
   assign read_port_width     = st_ff.rwid;
   assign full_flag_n         = st_ff.full_out_n;
   assign write_pointer_clear = (st_ff.state == fwp_pkg::FWP_ST_RESET);
   assign drop_count_pulse    = st_ff.drop;

endmodule

/* File: rtl/fwp_pkg.sv */
// Shared constants for the write port and reset-time configuration block
package fwp_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int unsigned DATA_W   = 36;
   localparam int unsigned OFFS_W   = 10;
   localparam int unsigned BMS_W    = 4;
   localparam int unsigned OSEL_W   = 2;
   localparam int unsigned PWID_W   = 2;

   // ----------------------------------------
   // Default flag offsets, one per select code
   // ----------------------------------------
   localparam logic [OFFS_W-1:0] OFFS_SEL0 = 10'h07f;
   localparam logic [OFFS_W-1:0] OFFS_SEL1 = 10'h0ff;
   localparam logic [OFFS_W-1:0] OFFS_SEL2 = 10'h1ff;
   localparam logic [OFFS_W-1:0] OFFS_SEL3 = 10'h3ff;

   // ----------------------------------------
   // Port width codes
   // ----------------------------------------
   localparam logic [PWID_W-1:0] PWID_X36 = 2'h0;
   localparam logic [PWID_W-1:0] PWID_X18 = 2'h1;
   localparam logic [PWID_W-1:0] PWID_X9  = 2'h2;

   // ----------------------------------------
   // Buffer sizing
   // ----------------------------------------
   localparam int unsigned BUF_DEPTH = 2;
   localparam logic [1:0]  CNT_ZERO  = 2'h0;
   localparam logic [1:0]  CNT_FULL  = 2'h2;

   // ----------------------------------------
   // Write port states
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      FWP_ST_RESET = 2'b00,
      FWP_ST_RUN   = 2'b01
   } fwp_state_e;

endpackage

/* File: rtl/fwp_skid_buf.sv */
// Two-entry valid/ready buffer on the write data path
`timescale 1ns/1ps

module fwp_skid_buf
(
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // Fill side
   input  wire logic                        in_valid,
   output logic                             in_ready,
   input  wire logic [fwp_pkg::DATA_W-1:0]  in_data,
   // Drain side
   output logic                             out_valid,
   input  wire logic                        out_ready,
   output logic [fwp_pkg::DATA_W-1:0]       out_data
);

   typedef struct packed
   {
      logic [fwp_pkg::DATA_W-1:0] mem0;
      logic [fwp_pkg::DATA_W-1:0] mem1;
      logic                       wp;
      logic                       rp;
      logic [1:0]                 cnt;
   } fwp_buf_s;

   fwp_buf_s buf_ff;
   fwp_buf_s nxt_buf;
   logic     push;
   logic     pop;

   assign in_ready  = (buf_ff.cnt != fwp_pkg::CNT_FULL);
   assign out_valid = (buf_ff.cnt != fwp_pkg::CNT_ZERO);
   assign out_data  = buf_ff.rp ? buf_ff.mem1 : buf_ff.mem0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      nxt_buf = buf_ff;
      if (push)
      begin
         if (buf_ff.wp)
            nxt_buf.mem1 = in_data;
         else
            nxt_buf.mem0 = in_data;
         nxt_buf.wp = ~buf_ff.wp;
      end
      if (pop)
         nxt_buf.rp = ~buf_ff.rp;
      if (push && !pop)
         nxt_buf.cnt = buf_ff.cnt + 2'h1;
      else if (pop && !push)
         nxt_buf.cnt = buf_ff.cnt - 2'h1;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         buf_ff <= '0;
      else
         buf_ff <= nxt_buf;
   end

endmodule

/* File: verif/fwp_write_port_checker.sv */
// Assertion checker for the write port block
`timescale 1ns/1ps
module fwp_write_port_checker
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // Straps and reset pin
   input wire logic        master_reset_n,
   input wire logic [1:0]  flag_offset_select,
   input wire logic        fall_through_mode_select,
   input wire logic        depth_expansion_select,
   input wire logic [3:0]  bus_width_select,
   // Outputs under watch
   input wire logic        store_valid,
   input wire logic        store_ready,
   input wire logic [35:0] store_data,
   input wire logic        store_full,
   input wire logic [9:0]  almost_empty_offset,
   input wire logic [9:0]  almost_full_offset,
   input wire logic        fall_through_mode,
   input wire logic [1:0]  write_port_width,
   input wire logic [1:0]  read_port_width,
   input wire logic        full_flag_n,
   input wire logic        write_pointer_clear,
   input wire logic        drop_count_pulse
);
   logic [9:0] exp_offs;
   always_comb
   begin
      case (flag_offset_select)
         2'h0: exp_offs = fwp_pkg::OFFS_SEL0;
         2'h1: exp_offs = fwp_pkg::OFFS_SEL1;
         2'h2: exp_offs = fwp_pkg::OFFS_SEL2;
         default: exp_offs = fwp_pkg::OFFS_SEL3;
      endcase
   end
   function automatic logic [1:0] pw(input logic [1:0] c);
      return c == 2'h0 ? fwp_pkg::PWID_X36 : (c == 2'h1 ? fwp_pkg::PWID_X18 : fwp_pkg::PWID_X9);
   endfunction
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_run;
      (master_reset_n && !write_pointer_clear) [*4];
   endsequence
   a_offs_equal: assert property (almost_empty_offset == almost_full_offset)
      else $error("almost flag offsets differ");
   a_offs_decode: assert property (s_run |-> almost_empty_offset == exp_offs)
      else $error("offset does not match select code");
   a_mode_latch: assert property (s_run |-> fall_through_mode == fall_through_mode_select)
      else $error("fall-through mode not latched");
   a_width_latch: assert property (s_run |-> write_port_width == pw(bus_width_select[3:2])
      && read_port_width == pw(bus_width_select[1:0]))
      else $error("port widths not decoded");
   a_clear_enter: assert property ($fell(master_reset_n) |-> ##[1:4] write_pointer_clear)
      else $error("pointer clear missing in master reset");
   a_clear_leave: assert property (master_reset_n [*4] |-> !write_pointer_clear)
      else $error("reset state held after release");
   a_full_level: assert property (s_run ##0 store_full [*3]
      |-> full_flag_n == (fall_through_mode | depth_expansion_select))
      else $error("full output level wrong");
   a_store_hold: assert property (store_valid && !store_ready
      |=> store_valid && $stable(store_data))
      else $error("stalled word not held");
   a_drop_pulse: assert property (drop_count_pulse |=> !drop_count_pulse)
      else $error("drop pulse longer than one cycle");
endmodule

/* File: verif/fwp_producer.sv */
// Producer model driving the write port
`timescale 1ns/1ps
module fwp_producer
(
   // Write port pins
   output logic        write_clock,
   output logic        write_enable_n,
   output logic        write_chip_select_n,
   output logic [35:0] write_data
);
   initial
   begin
      write_clock = 1'h0;
      write_enable_n = 1'h1;
      write_chip_select_n = 1'h1;
      write_data = 36'h0;
   end
   // One write edge, 400 ns period; released data shows its inverse
   task automatic put(input logic [35:0] d, input logic en_n, input logic cs_n);
      write_data = d;
      write_enable_n = en_n;
      write_chip_select_n = cs_n;
      #200 write_clock = 1'h1;
      #100 write_data = ~d;
      write_chip_select_n = 1'h1;
      #100 write_clock = 1'h0;
   endtask
endmodule

/* File: verif/fwp_write_port_tb_top.sv */
// Self-checking bench for the write port block
`timescale 1ns/1ps
module fwp_write_port_tb_top;
   logic        mclk = 0, rst_n = 0, mrs_n = 1, asw_n = 1, fts = 0, des = 0, rdy = 1, sfull = 0;
   logic [1:0]  fs = 0;
   logic [3:0]  bws = 0;
   logic        wck, wen_n, wcs_n, sv, ft_o, ffn, wpc, drop;
   logic [35:0] wd, sd;
   logic [9:0]  ae_o, af_o;
   logic [1:0]  wpw, rpw;
   logic [35:0] q[$];
   int          fails = 0, num_checks = 0, drops = 0, cyc = 0;
   logic [9:0]  otab[4] = '{fwp_pkg::OFFS_SEL0, fwp_pkg::OFFS_SEL1, fwp_pkg::OFFS_SEL2,
                            fwp_pkg::OFFS_SEL3};
   logic [1:0]  ptab[4] = '{fwp_pkg::PWID_X36, fwp_pkg::PWID_X18, fwp_pkg::PWID_X9,
                            fwp_pkg::PWID_X9};
   always #25 mclk = ~mclk;
   fwp_producer p (.write_clock(wck), .write_enable_n(wen_n), .write_chip_select_n(wcs_n),
      .write_data(wd));
   fwp_write_port dut (.mclk(mclk), .rst_n(rst_n), .master_reset_n(mrs_n),
      .async_write_select_n(asw_n), .flag_offset_select(fs), .fall_through_mode_select(fts),
      .depth_expansion_select(des), .bus_width_select(bws), .write_clock(wck),
      .write_enable_n(wen_n), .write_chip_select_n(wcs_n), .write_data(wd),
      .store_valid(sv), .store_ready(rdy), .store_data(sd), .store_full(sfull),
      .almost_empty_offset(ae_o), .almost_full_offset(af_o), .fall_through_mode(ft_o),
      .write_port_width(wpw), .read_port_width(rpw), .full_flag_n(ffn),
      .write_pointer_clear(wpc), .drop_count_pulse(drop));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
      num_checks++;
      if (s !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (sv === 1'h1 && rdy)
         q.push_back(sd);
      if (drop === 1'h1)
         drops++;
      if (cyc == 2000)
      begin
         fails++;
         end_sim();
      end
   end
   // Straps set while master reset is low, then held
   task automatic mr(input logic an, input logic [1:0] f, input logic ft, input logic de,
                     input logic [3:0] bw);
      @(negedge mclk);
      {asw_n, fs, fts, des, bws} = {an, f, ft, de, bw};
      mrs_n = 1'h0;
      repeat (4) @(negedge mclk);
      chk("clear_on", 1'h1, wpc);
      mrs_n = 1'h1;
      repeat (5) @(negedge mclk);
      chk("clear_off", 1'h0, wpc);
   endtask
   task automatic t_cfg();
      for (int i = 0; i < 4; i++)
      begin
         mr(1'h1, i[1:0], i[0], 1'h0, {i[1:0], ~i[1:0]});
         chk("ae_offs", otab[i], ae_o);
         chk("af_offs", otab[i], af_o);
         chk("ft_mode", i[0], ft_o);
         chk("wr_width", ptab[i], wpw);
         chk("rd_width", ptab[3-i], rpw);
      end
   endtask
   task automatic t_words(input logic an);
      mr(an, 2'h0, 1'h0, 1'h0, 4'h0);
      q.delete();
      p.put(36'h9_a5c3_0f1e, 1'h0, 1'h0);
      p.put(36'h1_1111_1111, an, 1'h0);
      p.put(36'h2_2222_2222, 1'h0, 1'h1);
      repeat (6) @(negedge mclk);
      chk("words", an ? 36'h1 : 36'h2, 36'(q.size()));
      chk("first", 36'h9_a5c3_0f1e, q[0]);
   endtask
   task automatic t_stall();
      mr(1'h1, 2'h0, 1'h0, 1'h0, 4'h0);
      rdy = 1'h0;
      drops = 0;
      q.delete();
      for (int k = 0; k < 4; k++)
         p.put(36'ha0 + 36'(k), 1'h0, 1'h0);
      chk("full_std", 1'h0, ffn);
      chk("drops", 36'h1, 36'(drops));
      rdy = 1'h1;
      repeat (8) @(negedge mclk);
      chk("drained", 36'h3, 36'(q.size()));
      for (int k = 0; k < 3; k++)
         chk("order", 36'ha0 + 36'(k), q[k]);
   endtask
   task automatic t_full();
      for (int k = 0; k < 3; k++)
      begin
         mr(1'h1, 2'h0, k == 2, k == 1, 4'h0);
         sfull = 1'h1;
         repeat (3) @(negedge mclk);
         chk("ff_full", k != 0, ffn);
         sfull = 1'h0;
         repeat (3) @(negedge mclk);
         chk("ff_space", k == 0, ffn);
      end
   endtask
   initial
   begin
      repeat (12) @(negedge mclk);
      rst_n = 1'h1;
      t_cfg();
      t_words(1'h1);
      t_words(1'h0);
      t_stall();
      t_full();
      end_sim();
   end
endmodule
bind fwp_write_port fwp_write_port_checker u_chk (.*);
